// File: rtl/tbil_loader.sv
module tbil_loader #(
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic        core_clk_i,        // core clock
  input  wire logic        srst_i,            // sync reset, high
  input  wire logic        chip_rst_n_i,      // chip reset pin, low
  input  wire logic [2:0]  boot_mode_strap_i, // strap pins 2..0
  input  wire logic [31:0] security_reg_i,    // security register
  input  wire logic        flash_miso_i,      // spi master data in
  input  wire logic [3:0]  quad_data_lines_i, // quad data pins in
  input  wire logic        spis_ss_n_i,       // slave select pin
  input  wire logic        spis_sclk_i,       // slave clock pin
  input  wire logic        spis_mosi_i,       // slave data pin
  input  wire logic [1:0]  link_rx_i,         // link receive wires
  input  wire logic [31:0] otp_data_i,        // otp read word
  input  wire logic        otp_valid_i,       // otp word valid
  output logic             gpio_pulldown_o,   // pull-downs on all gpio
  output logic             link_pulldown_o,   // pull-downs on link pins
  output tbil_pkg::tbil_pin_en_t pin_en_o,    // enabled boot pins
  output tbil_pkg::tbil_src_t    boot_src_o,  // chosen boot source
  output logic             flash_ss_n_o,      // flash select
  output logic             flash_sclk_o,      // flash clock
  output logic             flash_mosi_o,      // spi master data out
  output logic [3:0]       quad_data_lines_o, // quad data pins out
  output logic [3:0]       quad_data_lines_oe_o, // quad drive enable
  output logic [1:0]       link_tx_o,         // link transmit wires
  output logic             chanend0_alloc_o,  // channel end 0 in use
  output logic [31:0]      ack_chan_o,        // acknowledge channel
  output logic             otp_rd_o,          // otp read strobe
  output logic [15:0]      otp_addr_o,        // otp word address
  output tbil_pkg::tbil_ram_wr_t ram_wr_o,    // ram write port
  output logic             run_o,             // program started
  output logic [31:0]      exec_addr_o,       // start address
  output logic             crc_fail_o         // image rejected
);

  if (ADDR_W < 1 || ADDR_W > 30)
  begin : g_chk
    $error("ADDR_W must lie in 1..30");
  end

  typedef enum logic [5:0] {
    ST_RESET = 6'b000001,
    ST_DELAY = 6'b000010,
    ST_CMD   = 6'b000100,
    ST_LOAD  = 6'b001000,
    ST_RUN   = 6'b010000,
    ST_FAIL  = 6'b100000
  } tbil_state_t;

  typedef enum logic [6:0] {
    PH_ACK   = 7'b0000001,
    PH_LEN   = 7'b0000010,
    PH_PROG  = 7'b0000100,
    PH_CRC   = 7'b0001000,
    PH_END   = 7'b0010000,
    PH_TX    = 7'b0100000,
    PH_DONE  = 7'b1000000
  } tbil_phase_t;

  localparam int unsigned SYNC_W = 14;

  function automatic tbil_pkg::tbil_src_t decode_src(input logic [2:0]  s,
                                                     input logic [31:0] sec);
    if (sec[tbil_pkg::SECURE_BOOT_BIT])
      return tbil_pkg::SRC_OTP;
    else if (s[2])
      return tbil_pkg::SRC_LINK;
    else if (s[1])
      return tbil_pkg::SRC_SPIS;
    else if (s[0])
      return tbil_pkg::SRC_SPIM;
    else
      return tbil_pkg::SRC_QSPI;
  endfunction

  // two-stage synchronisers for every pin input
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  always_ff @(posedge core_clk_i)
  begin
    sync_a <= {chip_rst_n_i, boot_mode_strap_i, quad_data_lines_i,
               flash_miso_i, spis_ss_n_i, spis_sclk_i, spis_mosi_i,
               link_rx_i};
    sync_b <= sync_a;
  end

  logic       rst_n_s;
  logic [2:0] strap_s;
  logic [3:0] quad_s;
  logic       miso_s;
  logic       ss_n_s;
  logic       sclk_s;
  logic       mosi_s;
  logic [1:0] rx_s;
  assign {rst_n_s, strap_s, quad_s, miso_s, ss_n_s, sclk_s, mosi_s, rx_s}
    = sync_b;

  tbil_state_t         state;
  tbil_phase_t         phase;
  tbil_pkg::tbil_src_t src;
  logic [15:0] dly_cnt;
  logic        load_ok;
  logic        load_bad;
  logic        is_master;
  assign is_master = (src == tbil_pkg::SRC_QSPI) ||
                     (src == tbil_pkg::SRC_SPIM);
  assign boot_src_o = src;

  // strap and security decode taken once, in the reset state;
  // link set latched too, the strap pins may turn into gpio later
  logic [1:0] link_sel;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      src      <= tbil_pkg::SRC_QSPI;
      link_sel <= 2'b00;
    end
    else if (state == ST_RESET && rst_n_s)
    begin
      src      <= decode_src(strap_s, security_reg_i);
      link_sel <= strap_s[1:0];
    end
  end

  logic [31:0] cmd_sr;
  logic [4:0]  cmd_cnt;
  logic [7:0]  half_cnt;
  logic        sclk_rise;
  logic        sclk_fall;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !rst_n_s)
      state <= ST_RESET;
    else
    begin
      unique case (state)
        ST_RESET: state <= ST_DELAY;
        ST_DELAY:
          if (dly_cnt == 16'(tbil_pkg::BOOT_DELAY_CYC - 1))
            state <= is_master ? ST_CMD : ST_LOAD;
        ST_CMD:
          if (sclk_fall && cmd_cnt == 5'h1F)
            state <= ST_LOAD;
        ST_LOAD:
          if (load_ok)
            state <= ST_RUN;
          else if (load_bad)
            state <= ST_FAIL;
        ST_RUN:  state <= ST_RUN;
        ST_FAIL: state <= ST_FAIL;
      endcase
    end
  end

  // one counter serves the boot delay and the link enable delay
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || state == ST_RESET || (state == ST_DELAY &&
        dly_cnt == 16'(tbil_pkg::BOOT_DELAY_CYC - 1)))
      dly_cnt <= 16'h0000;
    else if (dly_cnt != 16'hFFFF)
      dly_cnt <= dly_cnt + 16'h0001;
  end

  logic link_up;
  assign link_up = (src == tbil_pkg::SRC_LINK) && (state == ST_LOAD) &&
                   (dly_cnt >= 16'(tbil_pkg::LINK_EN_CYC));

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || state == ST_RESET)
    begin
      gpio_pulldown_o <= 1'b1;
      link_pulldown_o <= 1'b1;
      pin_en_o        <= '0;
    end
    else
    begin
      gpio_pulldown_o <= 1'b0;
      // fixed pin sets, nothing here is software reachable
      pin_en_o.qspi <= (src == tbil_pkg::SRC_QSPI);
      pin_en_o.spim <= (src == tbil_pkg::SRC_SPIM);
      pin_en_o.spis <= (src == tbil_pkg::SRC_SPIS);
      if (link_up)
      begin
        link_pulldown_o   <= 1'b0;
        pin_en_o.link_set <= 4'h1 << link_sel;
        pin_en_o.link_5w  <= (link_sel != 2'b00);
      end
    end
  end

  // flash master clock: mode 0, idle low, sample on rise
  logic [7:0] half_max;
  assign half_max = (src == tbil_pkg::SRC_QSPI) ?
                    8'(tbil_pkg::QSPI_HALF_CYC - 1) :
                    8'(tbil_pkg::SPIM_HALF_CYC - 1);
  logic spi_active;
  assign spi_active = is_master && (state == ST_CMD ||
                      (state == ST_LOAD && phase != PH_DONE));
  assign sclk_rise = spi_active && half_cnt == half_max && !flash_sclk_o;
  assign sclk_fall = spi_active && half_cnt == half_max && flash_sclk_o;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !spi_active)
    begin
      half_cnt     <= 8'h00;
      flash_sclk_o <= 1'b0;
    end
    else if (half_cnt == half_max)
    begin
      half_cnt     <= 8'h00;
      flash_sclk_o <= !flash_sclk_o;
    end
    else
      half_cnt <= half_cnt + 8'h01;
  end

  // read command then address, shifted out on the falling edge
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || state == ST_DELAY)
    begin
      cmd_sr  <= {tbil_pkg::FLASH_READ_CMD,
                  tbil_pkg::FLASH_ADDR};
      cmd_cnt <= 5'h00;
    end
    else if (state == ST_CMD && sclk_fall)
    begin
      cmd_sr  <= {cmd_sr[30:0], 1'b0};
      cmd_cnt <= cmd_cnt + 5'h01;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      flash_ss_n_o         <= 1'b1;
      flash_mosi_o         <= 1'b0;
      quad_data_lines_o    <= 4'h0;
      quad_data_lines_oe_o <= 4'h0;
    end
    else
    begin
      flash_ss_n_o <= !spi_active;
      flash_mosi_o <= (src == tbil_pkg::SRC_SPIM) && state == ST_CMD &&
                      cmd_sr[31];
      // command goes out on line 0, the lines turn round for data
      quad_data_lines_o    <= {3'h0, (state == ST_CMD) && cmd_sr[31]};
      quad_data_lines_oe_o <= {3'h0, (src == tbil_pkg::SRC_QSPI) &&
                               state == ST_CMD};
    end
  end

  // byte capture from whichever source is active
  logic       sclk_q;
  logic [1:0] rx_q;
  logic [7:0] rx_sr;
  logic [2:0] rx_cnt;
  logic [8:0] tok_sr;
  logic [3:0] tok_cnt;
  logic [31:0] otp_word;
  logic [2:0] otp_left;
  logic       otp_wait;
  logic       byte_vld;
  logic [7:0] byte_q;
  logic       end_tok;
  logic       slave_rise;
  logic       rx_bit_vld;
  logic       rx_bit;
  logic [8:0] tok_next;
  logic       want_bytes;
  assign want_bytes = (state == ST_LOAD) && phase != PH_TX &&
                      phase != PH_DONE;
  assign slave_rise = sclk_s && !sclk_q && !ss_n_s; // both modes sample on rise
  assign rx_bit_vld = link_up && ((rx_s ^ rx_q) == 2'b01 ||
                                  (rx_s ^ rx_q) == 2'b10);
  assign rx_bit     = (rx_s ^ rx_q) == 2'b10;
  assign tok_next   = {rx_bit, tok_sr[8:1]};

  always_ff @(posedge core_clk_i)
  begin
    sclk_q <= sclk_s;
    // wires held low by the partner until traffic starts
    rx_q   <= link_up ? rx_s : 2'b00;
  end

  always_ff @(posedge core_clk_i)
  begin
    byte_vld <= 1'b0;
    end_tok  <= 1'b0;
    otp_rd_o <= 1'b0;
    if (srst_i || state == ST_RESET)
    begin
      rx_sr      <= 8'h00;
      rx_cnt     <= 3'h0;
      tok_sr     <= 9'h000;
      tok_cnt    <= 4'h0;
      otp_word   <= 32'h00000000;
      otp_left   <= 3'h0;
      otp_wait   <= 1'b0;
      otp_addr_o <= tbil_pkg::OTP_BASE;
      byte_q     <= 8'h00;
    end
    else if (want_bytes)
    begin
      unique case (src)
        tbil_pkg::SRC_SPIM:
          if (sclk_rise)
          begin
            rx_sr  <= {miso_s, rx_sr[7:1]};
            rx_cnt <= rx_cnt + 3'h1;
            byte_q <= {miso_s, rx_sr[7:1]};
            byte_vld <= (rx_cnt == 3'h7);
          end
        tbil_pkg::SRC_QSPI:
          if (sclk_rise)
          begin
            rx_sr  <= {quad_s, rx_sr[7:4]};
            rx_cnt <= {2'b00, !rx_cnt[0]};
            byte_q <= {quad_s, rx_sr[7:4]};
            byte_vld <= rx_cnt[0];
          end
        tbil_pkg::SRC_SPIS:
          if (ss_n_s)
            rx_cnt <= 3'h0; // deselect drops a partial byte
          else if (slave_rise)
          begin
            rx_sr  <= {mosi_s, rx_sr[7:1]};
            rx_cnt <= rx_cnt + 3'h1;
            byte_q <= {mosi_s, rx_sr[7:1]};
            byte_vld <= (rx_cnt == 3'h7);
          end
        tbil_pkg::SRC_LINK:
          if (rx_bit_vld)
          begin
            // token: control flag first, then eight data bits lsb first
            tok_sr <= tok_next;
            if (tok_cnt == 4'(tbil_pkg::TOKEN_BITS - 1))
            begin
              tok_cnt  <= 4'h0;
              byte_q   <= tok_next[8:1];
              byte_vld <= !tok_next[0];
              end_tok  <= tok_next[0] &&
                          tok_next[8:1] == tbil_pkg::LINK_END_TOKEN;
            end
            else
              tok_cnt <= tok_cnt + 4'h1;
          end
        tbil_pkg::SRC_OTP:
          if (otp_left != 3'h0)
          begin
            byte_q   <= otp_word[7:0];
            otp_word <= {8'h00, otp_word[31:8]};
            otp_left <= otp_left - 3'h1;
            byte_vld <= 1'b1;
          end
          else if (otp_wait)
          begin
            if (otp_valid_i)
            begin
              otp_word   <= otp_data_i;
              otp_left   <= 3'h4;
              otp_wait   <= 1'b0;
              otp_addr_o <= otp_addr_o + 16'h0001;
            end
          end
          else
          begin
            otp_rd_o <= 1'b1;
            otp_wait <= 1'b1;
          end
      endcase
    end
  end

  // word assembly, crc, ram writes and the link tail
  logic [31:0] word_sr;
  logic [1:0]  wb_cnt;
  logic [31:0] word_w;
  logic [31:0] prog_len;
  logic [31:0] prog_cnt;
  logic [31:0] crc_q;
  logic        crc_en;
  logic [8:0]  tx_sr;
  logic [3:0]  tx_cnt;
  logic [3:0]  tx_gap;
  assign word_w = {byte_q, word_sr[31:8]};
  assign crc_en = byte_vld && (phase == PH_LEN || phase == PH_PROG);

  tbil_crc32 u_crc (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .init_i     (state == ST_DELAY),
    .en_i       (crc_en),
    .byte_i     (byte_q),
    .crc_o      (crc_q)
  );

  always_ff @(posedge core_clk_i)
  begin
    load_ok     <= 1'b0;
    load_bad    <= 1'b0;
    ram_wr_o.we <= 1'b0;
    if (srst_i || state == ST_RESET)
    begin
      phase            <= PH_LEN;
      word_sr          <= 32'h00000000;
      wb_cnt           <= 2'h0;
      prog_len         <= 32'h00000000;
      prog_cnt         <= 32'h00000000;
      ack_chan_o       <= tbil_pkg::NULL_CHAN;
      chanend0_alloc_o <= 1'b0;
      crc_fail_o       <= 1'b0;
      ram_wr_o.addr    <= 30'h00000000;
      ram_wr_o.data    <= 32'h00000000;
      link_tx_o        <= 2'b00;
      tx_sr            <= {tbil_pkg::LINK_END_TOKEN, 1'b1};
      tx_cnt           <= 4'h0;
      tx_gap           <= 4'h0;
    end
    else if (state == ST_DELAY && src == tbil_pkg::SRC_LINK)
    begin
      phase            <= PH_ACK;
      chanend0_alloc_o <= 1'b1;
    end
    else if (byte_vld && want_bytes)
    begin
      word_sr <= word_w;
      wb_cnt  <= wb_cnt + 2'h1;
      if (wb_cnt == 2'h3)
      begin
        unique case (phase)
          PH_ACK:
          begin
            ack_chan_o <= word_w;
            phase      <= PH_LEN;
          end
          PH_LEN:
          begin
            prog_len <= word_w;
            prog_cnt <= 32'h00000000;
            phase    <= (word_w == 32'h00000000) ? PH_CRC : PH_PROG;
          end
          PH_PROG:
          begin
            ram_wr_o.we   <= 1'b1;
            ram_wr_o.addr <= 30'(tbil_pkg::RAM_BASE[31:2] +
                                 {{(32-ADDR_W){1'b0}},
                                  prog_cnt[ADDR_W-1:0]});
            ram_wr_o.data <= word_w;
            prog_cnt      <= prog_cnt + 32'h00000001;
            if (prog_cnt == prog_len - 32'h00000001)
              phase <= PH_CRC;
          end
          PH_CRC:
          begin
            crc_fail_o <= !(word_w == tbil_pkg::CRC_SKIP ||
                            word_w == ~crc_q);
            if (src == tbil_pkg::SRC_LINK)
              phase <= PH_END;
            else
            begin
              phase    <= PH_DONE;
              load_ok  <= (word_w == tbil_pkg::CRC_SKIP || word_w == ~crc_q);
              load_bad <= !(word_w == tbil_pkg::CRC_SKIP ||
                            word_w == ~crc_q);
            end
          end
          default: phase <= phase;
        endcase
      end
    end
    else if (phase == PH_END && end_tok)
      phase <= (ack_chan_o == tbil_pkg::NULL_CHAN) ? PH_DONE :
               PH_TX;
    else if (phase == PH_TX)
    begin
      // end token toward the ack channel, one wire toggle per bit
      if (tx_gap != 4'(tbil_pkg::LINK_TX_GAP_CYC - 1))
        tx_gap <= tx_gap + 4'h1;
      else
      begin
        tx_gap    <= 4'h0;
        link_tx_o <= link_tx_o ^ (tx_sr[0] ? 2'b10 : 2'b01);
        tx_sr     <= {1'b0, tx_sr[8:1]};
        tx_cnt    <= tx_cnt + 4'h1;
        if (tx_cnt == 4'(tbil_pkg::TOKEN_BITS - 1))
          phase <= PH_DONE;
      end
    end
    else if (phase == PH_DONE && src == tbil_pkg::SRC_LINK &&
             chanend0_alloc_o)
    begin
      chanend0_alloc_o <= 1'b0;
      load_ok          <= !crc_fail_o;
      load_bad         <= crc_fail_o;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || state != ST_RUN)
    begin
      run_o       <= 1'b0;
      exec_addr_o <= 32'h00000000;
    end
    else
    begin
      run_o       <= 1'b1;
      exec_addr_o <= tbil_pkg::RAM_BASE;
    end
  end

endmodule

// File: rtl/tbil_pkg.sv
package tbil_pkg;

  // timing: core clock and the reference core rate the ratios refer to
  localparam int unsigned CORE_HZ          = 10_000_000;
  localparam int unsigned REF_CORE_KHZ     = 400_000;
  localparam int unsigned QSPI_SCLK_KHZ    = 50_000;
  localparam int unsigned SPIM_SCLK_KHZ    = 2_500;
  localparam int unsigned BOOT_DELAY_NS    = 15_000;
  localparam int unsigned LINK_EN_NS       = 2_000;
  localparam int unsigned CORE_PERIOD_NS   = 1_000_000_000 / CORE_HZ;
  // least times round up
  localparam int unsigned BOOT_DELAY_CYC   =
    (BOOT_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned LINK_EN_CYC      =
    (LINK_EN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // sclk keeps the same ratio to the core clock as at the reference rate
  localparam int unsigned QSPI_HALF_CYC    = REF_CORE_KHZ / QSPI_SCLK_KHZ / 2;
  localparam int unsigned SPIM_HALF_CYC    = REF_CORE_KHZ / SPIM_SCLK_KHZ / 2;
  localparam int unsigned LINK_TX_GAP_CYC  = 8;

  // image format
  localparam logic [31:0] CRC_SKIP         = 32'h0D15AB1E;
  localparam logic [31:0] CRC_POLY         = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT         = 32'hFFFFFFFF;
  localparam logic [31:0] NULL_CHAN        = 32'h0000FF02;
  localparam logic [7:0]  FLASH_READ_CMD   = 8'h03;
  localparam logic [23:0] FLASH_ADDR       = 24'h000000;
  localparam logic [7:0]  LINK_END_TOKEN   = 8'h01;
  localparam int unsigned TOKEN_BITS       = 9;
  localparam int unsigned SECURE_BOOT_BIT  = 5;
  localparam logic [15:0] OTP_BASE         = 16'h0000;
  localparam logic [31:0] RAM_BASE         = 32'h00000000;

  typedef enum logic [4:0] {
    SRC_QSPI = 5'b00001,
    SRC_SPIM = 5'b00010,
    SRC_SPIS = 5'b00100,
    SRC_LINK = 5'b01000,
    SRC_OTP  = 5'b10000
  } tbil_src_t;

  typedef struct packed {
    logic       qspi;      // select, four data lines, clock
    logic       spim;      // miso, select, clock, mosi
    logic       spis;      // select, clock, mosi
    logic [3:0] link_set;  // one bit per link strap code 100..111
    logic       link_5w;   // link wires per direction: 0 two, 1 five
  } tbil_pin_en_t;

  typedef struct packed {
    logic        we;
    logic [29:0] addr;
    logic [31:0] data;
  } tbil_ram_wr_t;

endpackage

// File: rtl/tbil_crc32.sv
module tbil_crc32 (
  input  wire logic       core_clk_i, // core clock
  input  wire logic       srst_i,     // sync reset
  input  wire logic       init_i,     // preset the register
  input  wire logic       en_i,       // fold one byte in
  input  wire logic [7:0] byte_i,     // byte to fold
  output logic      [31:0] crc_o      // running register, not inverted
);

  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ tbil_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || init_i)
      crc_o <= tbil_pkg::CRC_INIT;
    else if (en_i)
      crc_o <= crc_step(crc_o, byte_i);
  end

endmodule

// File: tb/tbil_loader_checker.sv
module tbil_loader_checker (
  input wire logic              core_clk_i,      // core clock
  input wire logic              srst_i,          // sync reset
  input wire logic              chip_rst_n_i,    // chip reset pin
  input wire logic              gpio_pulldown_o, // pull-downs
  input tbil_pkg::tbil_pin_en_t pin_en_o,        // boot pins
  input tbil_pkg::tbil_src_t    boot_src_o,      // boot source
  input wire logic              flash_ss_n_o,    // flash select
  input wire logic              otp_rd_o,        // otp strobe
  input wire logic [15:0]       otp_addr_o,      // otp address
  input tbil_pkg::tbil_ram_wr_t ram_wr_o,        // ram write
  input wire logic              run_o,           // started
  input wire logic [31:0]       exec_addr_o,     // start address
  input wire logic              crc_fail_o       // rejected
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  logic [29:0] wr_cnt;
  logic [15:0] rd_cnt;
  // both counts restart with either reset, so first word must be zero
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !chip_rst_n_i)
    begin
      wr_cnt <= '0;
      rd_cnt <= '0;
    end
    else
    begin
      wr_cnt <= wr_cnt + 30'(ram_wr_o.we);
      rd_cnt <= rd_cnt + 16'(otp_rd_o);
    end
  end
  // pin reset passes two sync stages and the state register first
  pull_reset_a: assert property (
    !chip_rst_n_i [*5] |-> gpio_pulldown_o)
    else $error("pull-downs off in reset");
  run_addr_a: assert property (
    $rose(run_o) |-> exec_addr_o == 32'h0)
    else $error("start address not zero");
  run_fail_a: assert property (crc_fail_o |-> !run_o)
    else $error("rejected image started");
  src_hold_a: assert property (
    run_o && chip_rst_n_i |=> $stable(boot_src_o))
    else $error("boot source moved");
  otp_src_a: assert property (
    otp_rd_o |-> boot_src_o == tbil_pkg::SRC_OTP)
    else $error("otp read outside secure boot");
  otp_addr_a: assert property (
    otp_rd_o |-> otp_addr_o == rd_cnt)
    else $error("otp address out of order");
  ram_addr_a: assert property (
    ram_wr_o.we |-> ram_wr_o.addr == wr_cnt)
    else $error("ram address out of order");
  pin_spis_a: assert property (
    pin_en_o.spis |-> boot_src_o == tbil_pkg::SRC_SPIS)
    else $error("slave pins in wrong mode");
  ss_master_a: assert property (
    !flash_ss_n_o |-> boot_src_o inside
    {tbil_pkg::SRC_QSPI, tbil_pkg::SRC_SPIM})
    else $error("flash select in wrong mode");
  cover property ($rose(run_o));
  cover property ($rose(crc_fail_o));
  cover property (otp_rd_o);
endmodule

bind tbil_loader tbil_loader_checker u_chk (.core_clk_i, .srst_i,
  .chip_rst_n_i, .gpio_pulldown_o, .pin_en_o, .boot_src_o, .flash_ss_n_o,
  .otp_rd_o, .otp_addr_o, .ram_wr_o, .run_o, .exec_addr_o, .crc_fail_o);

// File: tb/tbil_spi_host.sv
module tbil_spi_host (
  output logic ss_n_o, // select to the loader
  output logic sclk_o, // serial clock
  output logic mosi_o  // serial data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    ss_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  task automatic start();
    #37 ss_n_o = 1'b0;
  endtask
  // mode 0: data set while clock low, taken on the rise
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      mosi_o = b[i];
      #400 sclk_o = 1'b1;
      #400 sclk_o = 1'b0;
    end
  endtask
  // released line shows no stale bit
  task automatic stop();
    #400 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
endmodule

// File: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i, srst_i, chip_rst_n_i, otp_valid_i, spis_ss_n_i;
  logic spis_sclk_i, spis_mosi_i, gpio_pulldown_o, flash_ss_n_o;
  logic otp_rd_o, run_o, crc_fail_o, flash_sclk_o, flash_mosi_o, sclk_d;
  logic link_pulldown_o, chanend0_alloc_o;
  logic [1:0]  link_tx_o;
  logic [3:0]  quad_o;
  logic [2:0]  boot_mode_strap_i;
  logic [15:0] otp_addr_o;
  logic [31:0] security_reg_i, otp_data_i, exec_addr_o, good_crc, c;
  logic [31:0] img [4];
  logic [31:0] wr_q [$];
  tbil_pkg::tbil_pin_en_t pin_en_o;
  tbil_pkg::tbil_src_t    boot_src_o, exp_src;
  tbil_pkg::tbil_ram_wr_t ram_wr_o;
  int err_total, tests_run, n, k, g;
  tbil_loader u_dut (.core_clk_i, .srst_i, .chip_rst_n_i, .boot_mode_strap_i,
    .security_reg_i, .flash_miso_i(1'b0), .quad_data_lines_i(4'h0),
    .spis_ss_n_i, .spis_sclk_i, .spis_mosi_i,
    .link_rx_i(2'h0),
    .otp_data_i, .otp_valid_i, .gpio_pulldown_o, .link_pulldown_o,
    .pin_en_o, .boot_src_o, .flash_ss_n_o, .flash_sclk_o,
    .flash_mosi_o, .quad_data_lines_o(quad_o), .quad_data_lines_oe_o(),
    .link_tx_o, .chanend0_alloc_o, .ack_chan_o(), .otp_rd_o,
    .otp_addr_o, .ram_wr_o, .run_o, .exec_addr_o, .crc_fail_o);
  tbil_spi_host u_host (.ss_n_o(spis_ss_n_i), .sclk_o(spis_sclk_i),
    .mosi_o(spis_mosi_i));
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // otp answers one cycle after each strobe
  always @(negedge core_clk_i)
  begin
    otp_valid_i <= otp_rd_o;
    otp_data_i <= img[otp_addr_o[1:0]];
  end
  always @(negedge core_clk_i)
    if (ram_wr_o.we === 1'b1)
      wr_q.push_back(ram_wr_o.data);
  function automatic logic [31:0] crc_add(logic [31:0] r, logic [7:0] b);
    r = r ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? (r >> 1) ^ 32'hEDB88320 : r >> 1;
    return r;
  endfunction
  task automatic check(string s, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic boot(logic [2:0] m, logic [31:0] sec);
    @(negedge core_clk_i);
    srst_i = 1'b1;
    chip_rst_n_i = 1'b0;
    boot_mode_strap_i = m;
    security_reg_i = sec;
    repeat (20) @(negedge core_clk_i);
    check("pulldown", 1, gpio_pulldown_o);
    srst_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    chip_rst_n_i = 1'b1;
    wr_q.delete();
  endtask
  task automatic load(logic [31:0] sec, logic [31:0] tr, logic ok);
    img[3] = tr;
    boot(3'b010, sec);
    repeat (200) @(negedge core_clk_i);
    if (sec == 0)
    begin
      u_host.start();
      for (int w = 0; w < 4; w++)
        for (int b = 0; b < 4; b++)
          u_host.send(img[w][8*b +: 8]);
      u_host.stop();
    end
    n = 0;
    while (run_o !== 1'b1 && crc_fail_o !== 1'b1 && n < 3000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 3000)
    begin
      err_total++;
      summarize();
    end
    repeat (4) @(negedge core_clk_i);
    check("run", ok, run_o);
    check("crc_fail", !ok, crc_fail_o);
    exp_src = sec[5] ? tbil_pkg::SRC_OTP : tbil_pkg::SRC_SPIS;
    check("src", exp_src, boot_src_o);
    check("exec", 0, exec_addr_o);
    check("words", 2, wr_q.size());
    for (int w = 0; w < 2; w++)
      check("ram", img[w+1], wr_q[w]);
  endtask
  initial
  begin
    srst_i = 1'b1;
    chip_rst_n_i = 1'b0;
    boot_mode_strap_i = 3'h0;
    security_reg_i = 32'h00000000;
    otp_valid_i = 1'b0;
    otp_data_i = 32'h00000000;
    img[0] = 32'h00000002;
    img[1] = 32'h12345678;
    img[2] = 32'hC3A50FF1;
    c = 32'hFFFFFFFF;
    for (int w = 0; w < 3; w++)
      for (int b = 0; b < 4; b++)
        c = crc_add(c, img[w][8*b +: 8]);
    good_crc = ~c;
    for (int m = 0; m < 8; m++)
    begin
      boot(m[2:0], 32'h00000000);
      n = 0;
      while (flash_ss_n_o === 1'b1 && n < 1600)
      begin
        @(negedge core_clk_i);
        n++;
        if (n == 10)
          boot_mode_strap_i = ~m[2:0];
      end
      check("ss_fall", m < 2, n >= 150 && n < 1600);
      // masters: 32 command bits, rises 8 or 160 core clocks apart
      if (m < 2)
      begin
        k = 0;
        for (int i = 0; k < 32 && i < 6000; i++)
        begin
          @(negedge core_clk_i);
          if (flash_sclk_o === 1'b1 && sclk_d === 1'b0)
          begin
            c = {c[30:0], m[0] ? flash_mosi_o : quad_o[0]};
            k++;
            n = (k == 1) ? i : n;
            g = i;
          end
          sclk_d = flash_sclk_o;
        end
        check("read_cmd", 32'h03000000, c);
        check("sclk_div", m[0] ? 32'h00001360 : 32'h000000F8,
          g - n);
      end
      exp_src = m[2] ? tbil_pkg::SRC_LINK : m[1] ? tbil_pkg::SRC_SPIS :
        m[0] ? tbil_pkg::SRC_SPIM : tbil_pkg::SRC_QSPI;
      check("strap_src", exp_src, boot_src_o);
      check("pins", {m == 0, m == 1, m[2:1] == 2'b01,
        m[2] ? 4'h1 << m[1:0] : 4'h0, m[2] && m[1:0] != 0, !m[2], m[2],
        2'b00}, {pin_en_o, link_pulldown_o, chanend0_alloc_o,
        link_tx_o});
    end
    load(32'h00000000, good_crc, 1'b1);
    load(32'h00000000, 32'h0D15AB1E, 1'b1);
    load(32'h00000000, good_crc ^ 32'h00000001, 1'b0);
    load(32'h00000020, good_crc, 1'b1);
    summarize();
  end
endmodule
